// ==== logic/gen_ctl_defs.svh ====
`ifndef GEN_CTL_DEFS_SVH
`define GEN_CTL_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define GENERAL_CONTROL_OFS   8'hd0
`define GENERAL_CONTROL_RST   32'h0000_0000
// Mask of implemented bits; everything else is reserved and reads zero.
`define GENERAL_CONTROL_MASK  32'h0300_39c7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_PAIR_B_SEL        25
`define BIT_HIDE_BRIDGE       24
`define BIT_FPU_ERR_EN        13
`define BIT_KBD_LATCH_EN      12
`define BIT_MOUSE_LATCH_EN    11
`define BIT_INTC_EN           8
`define BIT_INTC_EXT_EN       7
`define BIT_ALT_ACCESS_EN     6
`define BIT_DMA_COLLECT_BUFFER_ENABLE            2
`define BIT_DELAYED_EN        1
`define BIT_POS_DECODE        0

// ----------------------------------------------------------------------
// Legacy I/O ports
// ----------------------------------------------------------------------
`define PORT_FPU_CLEAR        16'h00f0
`define PORT_KBD_DATA         16'h0060

`endif

// ==== logic/gen_ctl_pkg.sv ====
package gen_ctl_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // How the PCI decoder should claim a cycle.
  typedef enum logic [1:0] {
    CLAIM_NONE        = 2'b00,
    CLAIM_POSITIVE    = 2'b01,
    CLAIM_SUBTRACTIVE = 2'b10
  } claim_t;

  // Interrupt controller decode mode.
  typedef enum logic [1:0] {
    INTC_OFF  = 2'b00,
    INTC_BASE = 2'b01,
    INTC_FULL = 2'b10
  } intc_mode_t;

endpackage

// ==== logic/irq_edge_latch.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Edge latch for a legacy interrupt, released by a clear pulse.
// ----------------------------------------------------------------------
module irq_edge_latch (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control
  input  wire logic latch_en,
  input  wire logic clear,
  // Interrupt in and out
  input  wire logic irq_in,
  output logic      irq_out
);

  logic prev_ff;  // Last sampled input level, for rising edge detection.
  logic held_ff;  // Captured edge awaiting the clear.

  // Track the previous level of the source.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= irq_in;
    end
  end

  // An edge in the same cycle as the clear wins, so no edge is lost.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      held_ff <= 1'b0;
    end else if (irq_in && !prev_ff && latch_en) begin
      held_ff <= 1'b1;
    end else if (clear || !latch_en) begin
      held_ff <= 1'b0;
    end
  end

  // Bypass passes the level straight through when latching is off.
  always_comb begin
    irq_out = latch_en ? held_ff : irq_in;
  end

endmodule

// ==== logic/fpu_error_ctl.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Coprocessor error to internal interrupt 13 and ignore-error output.
// ----------------------------------------------------------------------
module fpu_error_ctl (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control
  input  wire logic enable,
  input  wire logic clear,
  // Processor side
  input  wire logic fp_error_in_n,
  output logic      irq13,
  output logic      ignore_numeric_error_n
);

  logic hold_ff;  // Interrupt held until the clearing write.

  // A low error input sets the hold; a write clear only wins when the
  // error is no longer present, so a persisting error is not lost.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_ff <= 1'b0;
    end else if (!enable) begin
      hold_ff <= 1'b0;
    end else if (!fp_error_in_n) begin
      hold_ff <= 1'b1;
    end else if (clear) begin
      hold_ff <= 1'b0;
    end
  end

  // Registered outputs keep glitches off the processor pins.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq13                  <= 1'b0;
      ignore_numeric_error_n <= 1'b1;
    end else begin
      irq13                  <= enable && hold_ff;
      ignore_numeric_error_n <= !(enable && hold_ff);
    end
  end

endmodule

// ==== logic/general_control.sv ====
`timescale 1ns/1ps
`include "gen_ctl_defs.svh"

// Behaviour
// - Bit 25 selects PC/PCI protocol unless GPIO
// - Bit 24 keeps AD22 low for bridge configuration
// - Bit 13: error raises IRQ13, ignore-error
// - Bit 13 clear: no IRQ13, no ignore-error
// - Bit 12 latches keyboard IRQ until 60h read
// - Bit 11 latches mouse IRQ until 60h read
// - Bit 8 clear: no controller decode
// - Bits 8,7 = 1,0: base controller only
// - Bits 8,7 set: full decode, message writes
// - Bit 6 enables alternate register access mode
// - Bit 2 enables DMA collection buffer
// - Bit 1 enables delayed transactions
// - Bit 0 set: positive decode only
// - Bit 0 clear: subtractive claim to LPC
module general_control
  import gen_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // Configuration access, one dword per cycle
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rd,
  input  wire logic [7:0]           cfg_addr,
  input  wire logic [3:0]           cfg_be,
  input  wire logic [31:0]          cfg_wdata,
  output logic      [31:0]          cfg_rdata,
  // Legacy I/O port access seen by the bridge
  input  wire logic                 io_wr,
  input  wire logic                 io_rd,
  input  wire logic [15:0]          io_addr,
  // Request/grant pair B
  input  wire logic                 pair_b_gpio_sel,
  output logic                      pair_b_pcpci_mode,
  output logic                      pair_b_gpio_mode,
  // Configuration cycle addressing
  input  wire logic                 cfg_cycle_to_bridge,
  input  wire logic                 ad22_request,
  output logic                      ad22_drive,
  // Processor error interface
  input  wire logic                 fp_error_in_n,
  output logic                      irq13,
  output logic                      ignore_numeric_error_n,
  // Keyboard and mouse interrupts
  input  wire logic                 kbd_irq_in,
  input  wire logic                 mouse_irq_in,
  output logic                      kbd_irq_out,
  output logic                      mouse_irq_out,
  // Interrupt controller decode
  input  wire logic                 intc_base_hit,
  input  wire logic                 intc_ext_hit,
  input  wire logic                 msg_irq_write,
  output gen_ctl_pkg::intc_mode_t   intc_mode,
  output logic                      intc_base_decode,
  output logic                      intc_ext_decode,
  output logic                      msg_irq_accept,
  // Other steering bits
  output logic                      alternate_access_enable,
  output logic                      dma_collect_buffer_enable,
  output logic                      delayed_transaction_enable,
  // PCI claim decision
  input  wire logic                 pci_cycle,
  input  wire logic                 pci_internal_hit,
  input  wire logic                 pci_lpc_known_hit,
  input  wire logic                 pci_other_claimed,
  output gen_ctl_pkg::claim_t       pci_claim,
  output logic                      forward_to_lpc
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Expand byte enables to a bit mask.
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ----------------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------------
  logic [31:0] general_control_ff;   // Stored control value.
  logic [31:0] nxt_general_control;  // Value after a write.
  logic        hit;                  // Access targets this register.
  logic        port60_rd;            // Keyboard data port read.
  logic        portf0_wr;            // Coprocessor clear port write.

  always_comb begin
    hit = (cfg_addr == `GENERAL_CONTROL_OFS);
  end

  // Byte-enabled merge; reserved bits are masked so they never stick.
  always_comb begin
    nxt_general_control = general_control_ff;
    if (cfg_wr && hit) begin
      nxt_general_control = ((general_control_ff & ~be_mask(cfg_be)) |
                             (cfg_wdata & be_mask(cfg_be))) &
                            `GENERAL_CONTROL_MASK;
    end
  end

  // Core-well reset clears every implemented bit.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      general_control_ff <= `GENERAL_CONTROL_RST;
    end else begin
      general_control_ff <= nxt_general_control;
    end
  end

  // Read data is registered; other offsets answer zero.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      cfg_rdata <= hit ? (general_control_ff & `GENERAL_CONTROL_MASK)
                       : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Request/grant pair B and AD22 hiding
  // ----------------------------------------------------------------------
  // The GPIO selection overrides the protocol choice.
  always_comb begin
    pair_b_gpio_mode  = pair_b_gpio_sel;
    pair_b_pcpci_mode = general_control_ff[`BIT_PAIR_B_SEL] &&
                        !pair_b_gpio_sel;
  end

  // Hiding removes the IDSEL line so the legacy bridge stays unseen.
  always_comb begin
    ad22_drive = ad22_request &&
                 !(cfg_cycle_to_bridge &&
                   general_control_ff[`BIT_HIDE_BRIDGE]);
  end

  // ----------------------------------------------------------------------
  // Legacy interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    port60_rd = io_rd && (io_addr == `PORT_KBD_DATA);
    portf0_wr = io_wr && (io_addr == `PORT_FPU_CLEAR);
  end

  // Coprocessor error path, gated entirely by its enable.
  fpu_error_ctl u_fpu (
    .core_clk               (core_clk),
    .rst                    (rst),
    .enable                 (general_control_ff[`BIT_FPU_ERR_EN]),
    .clear                  (portf0_wr),
    .fp_error_in_n          (fp_error_in_n),
    .irq13                  (irq13),
    .ignore_numeric_error_n (ignore_numeric_error_n)
  );

  // Keyboard interrupt latch, cleared by a data port read.
  irq_edge_latch u_kbd (
    .core_clk (core_clk),
    .rst      (rst),
    .latch_en (general_control_ff[`BIT_KBD_LATCH_EN]),
    .clear    (port60_rd),
    .irq_in   (kbd_irq_in),
    .irq_out  (kbd_irq_out)
  );

  // Mouse interrupt latch shares the same clearing port.
  irq_edge_latch u_mouse (
    .core_clk (core_clk),
    .rst      (rst),
    .latch_en (general_control_ff[`BIT_MOUSE_LATCH_EN]),
    .clear    (port60_rd),
    .irq_in   (mouse_irq_in),
    .irq_out  (mouse_irq_out)
  );

  // ----------------------------------------------------------------------
  // Interrupt controller decode
  // ----------------------------------------------------------------------
  // The extension bit is a don't-care while the controller is off.
  always_comb begin
    if (!general_control_ff[`BIT_INTC_EN]) begin
      intc_mode = INTC_OFF;
    end else if (!general_control_ff[`BIT_INTC_EXT_EN]) begin
      intc_mode = INTC_BASE;
    end else begin
      intc_mode = INTC_FULL;
    end
  end

  // Message writes cannot be disabled separately in full mode.
  always_comb begin
    case (intc_mode)
      INTC_BASE: begin
        intc_base_decode = intc_base_hit;
        intc_ext_decode  = 1'b0;
        msg_irq_accept   = 1'b0;
      end
      INTC_FULL: begin
        intc_base_decode = intc_base_hit;
        intc_ext_decode  = intc_ext_hit;
        msg_irq_accept   = msg_irq_write;
      end
      default: begin
        intc_base_decode = 1'b0;
        intc_ext_decode  = 1'b0;
        msg_irq_accept   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Steering bits
  // ----------------------------------------------------------------------
  always_comb begin
    alternate_access_enable    = general_control_ff[`BIT_ALT_ACCESS_EN];
    dma_collect_buffer_enable  = general_control_ff[`BIT_DMA_COLLECT_BUFFER_ENABLE];
    delayed_transaction_enable = general_control_ff[`BIT_DELAYED_EN];
  end

  // ----------------------------------------------------------------------
  // PCI claim
  // ----------------------------------------------------------------------
  // Own addresses always claim positively; leftovers only when allowed.
  always_comb begin
    pci_claim      = CLAIM_NONE;
    forward_to_lpc = 1'b0;
    if (pci_cycle) begin
      if (pci_internal_hit || pci_lpc_known_hit) begin
        pci_claim      = CLAIM_POSITIVE;
        forward_to_lpc = pci_lpc_known_hit && !pci_internal_hit;
      end else if (!general_control_ff[`BIT_POS_DECODE] &&
                   !pci_other_claimed) begin
        pci_claim      = CLAIM_SUBTRACTIVE;
        forward_to_lpc = 1'b1;
      end
    end
  end

endmodule

// ==== testbench/gen_ctl_props.sv ====
`timescale 1ns/1ps
`include "gen_ctl_defs.svh"

// ----------------------------------------------------------------------
// Checker for the general control register and its steering outputs.
// ----------------------------------------------------------------------
module gen_ctl_props
  import gen_ctl_pkg::*;
(
  // Clock, reset and configuration access
  input wire logic                    core_clk, rst, cfg_wr, cfg_rd,
  input wire logic [7:0]              cfg_addr,
  input wire logic [3:0]              cfg_be,
  input wire logic [31:0]             cfg_wdata, cfg_rdata,
  // Legacy ports and interrupts
  input wire logic                    io_wr, io_rd,
  input wire logic [15:0]             io_addr,
  input wire logic                    fp_error_in_n, irq13,
  input wire logic                    ignore_numeric_error_n,
  input wire logic                    kbd_irq_in, kbd_irq_out,
  input wire logic                    mouse_irq_in, mouse_irq_out,
  // Steering inputs and outputs
  input wire logic                    pair_b_gpio_sel, pair_b_pcpci_mode,
  input wire logic                    cfg_cycle_to_bridge, ad22_request,
  input wire logic                    ad22_drive, intc_base_hit,
  input wire logic                    intc_ext_hit, msg_irq_write,
  input wire gen_ctl_pkg::intc_mode_t intc_mode,
  input wire logic                    intc_base_decode, intc_ext_decode,
  input wire logic                    msg_irq_accept,
  input wire logic                    alternate_access_enable,
  input wire logic                    dma_collect_buffer_enable,
  input wire logic                    delayed_transaction_enable,
  input wire logic                    pci_cycle, pci_internal_hit,
  input wire logic                    pci_lpc_known_hit, pci_other_claimed,
  input wire gen_ctl_pkg::claim_t     pci_claim,
  input wire logic                    forward_to_lpc
);
  localparam logic [31:0] impl_mask = `GENERAL_CONTROL_MASK;
  logic [31:0] lane_mask;   // Byte enables spread over the dword.
  logic [31:0] shadow_ff;   // Value the register should hold.
  logic [31:0] nxt_shadow;  // Shadow after a write to this register.
  logic        no_hit;      // A PCI cycle that nobody decodes positively.

  assign lane_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                      {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign nxt_shadow = (shadow_ff & ~lane_mask) |
                      (cfg_wdata & lane_mask & impl_mask);
  assign no_hit = pci_cycle && !pci_internal_hit && !pci_lpc_known_hit;

  // Track writes so every steering output has a reference value.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shadow_ff <= '0;
    end else if (cfg_wr && cfg_addr == `GENERAL_CONTROL_OFS) begin
      shadow_ff <= nxt_shadow;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // A held coprocessor error that is not being released this cycle.
  sequence s_fpu_keep;
    irq13 && shadow_ff[13] && !(io_wr && io_addr == `PORT_FPU_CLEAR) &&
    !$past(io_wr && io_addr == `PORT_FPU_CLEAR);
  endsequence
  // A data port read that should drop a latched keyboard request.
  sequence s_kbd_release;
    kbd_irq_out && io_rd && io_addr == `PORT_KBD_DATA && !$rose(kbd_irq_in);
  endsequence

  a_pair_b_sel: assert property (pair_b_pcpci_mode ==
    (shadow_ff[25] && !pair_b_gpio_sel)) else $error("pair b mode wrong");
  a_ad22_hide: assert property (ad22_drive == (ad22_request &&
    !(cfg_cycle_to_bridge && shadow_ff[24]))) else $error("ad22 wrong");
  a_fpu_raise: assert property (shadow_ff[13] && !fp_error_in_n
    |-> ##2 irq13 && !ignore_numeric_error_n) else $error("irq13 not raised");
  a_fpu_hold: assert property (s_fpu_keep |=> irq13)
    else $error("irq13 dropped early");
  a_fpu_quiet: assert property (!shadow_ff[13]
    |=> !irq13 && ignore_numeric_error_n) else $error("irq13 while off");
  a_kbd_latch: assert property (shadow_ff[12] && $rose(kbd_irq_in)
    |=> kbd_irq_out) else $error("keyboard edge lost");
  a_kbd_release: assert property (s_kbd_release
    |=> !kbd_irq_out || !shadow_ff[12]) else $error("keyboard not freed");
  a_kbd_bypass: assert property (!shadow_ff[12]
    |-> kbd_irq_out == kbd_irq_in) else $error("keyboard not bypassed");
  a_mouse_latch: assert property (shadow_ff[11] && $rose(mouse_irq_in)
    |=> mouse_irq_out) else $error("mouse edge lost");
  a_intc_mode: assert property (intc_mode == (!shadow_ff[8] ? INTC_OFF :
    shadow_ff[7] ? INTC_FULL : INTC_BASE)) else $error("intc mode wrong");
  a_intc_decode: assert property (intc_ext_decode ==
    (intc_ext_hit && shadow_ff[8] && shadow_ff[7]) && msg_irq_accept ==
    (msg_irq_write && shadow_ff[8] && shadow_ff[7]) && intc_base_decode ==
    (intc_base_hit && shadow_ff[8])) else $error("intc decode wrong");
  a_steer_bits: assert property ({alternate_access_enable,
    dma_collect_buffer_enable, delayed_transaction_enable} ==
    {shadow_ff[6], shadow_ff[2:1]}) else $error("steering bit wrong");
  a_claim_pos: assert property (pci_cycle && !no_hit
    |-> pci_claim == CLAIM_POSITIVE) else $error("positive claim missing");
  a_claim_sub: assert property (no_hit |-> forward_to_lpc ==
    (!shadow_ff[0] && !pci_other_claimed)) else $error("forward wrong");
  a_read_back: assert property (cfg_rd && cfg_addr == `GENERAL_CONTROL_OFS
    |=> cfg_rdata == $past(shadow_ff)) else $error("read back wrong");
endmodule

bind general_control gen_ctl_props u_gen_ctl_props (.*);

// ==== testbench/legacy_side_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Processor and keyboard controller lines seen by the bridge.
// ----------------------------------------------------------------------
module legacy_side_model (
  // Lines toward the bridge
  output logic fp_error_in_n,
  output logic kbd_irq_in,
  output logic mouse_irq_in
);
  // Idle levels: no error pending and both requests low.
  initial begin
    fp_error_in_n = 1'b1;
    kbd_irq_in    = 1'b0;
    mouse_irq_in  = 1'b0;
  end

  // Called just after a falling edge, so the bridge samples settled lines.
  task automatic drive(input logic f_n, input logic k, input logic m);
    fp_error_in_n = f_n;
    kbd_irq_in    = k;
    mouse_irq_in  = m;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`include "gen_ctl_defs.svh"

// ----------------------------------------------------------------------
// Register and steering test of the general control block.
// ----------------------------------------------------------------------
module tb_top;
  import gen_ctl_pkg::*;
  logic        core_clk, rst, cfg_wr, cfg_rd, io_wr, io_rd;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, v;
  logic [15:0] io_addr;
  logic        pair_b_gpio_sel, pair_b_pcpci_mode, pair_b_gpio_mode;
  logic        cfg_cycle_to_bridge, ad22_request, ad22_drive;
  logic        fp_error_in_n, irq13, ignore_numeric_error_n;
  logic        kbd_irq_in, mouse_irq_in, kbd_irq_out, mouse_irq_out;
  logic        intc_base_hit, intc_ext_hit, msg_irq_write, forward_to_lpc;
  intc_mode_t  intc_mode;
  logic        intc_base_decode, intc_ext_decode, msg_irq_accept;
  logic        alternate_access_enable, dma_collect_buffer_enable;
  logic        delayed_transaction_enable, pci_cycle, pci_internal_hit;
  logic        pci_lpc_known_hit, pci_other_claimed;
  claim_t      pci_claim;
  logic [8:0]  ins;          // Side inputs of one steering case.
  int          errors, total_checks;

  general_control   u_general_control (.*);
  legacy_side_model u_legacy_side_model (.*);

  // 50 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cycle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // One-cycle strobes; the trailing cycle keeps strobes apart.
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] b,
                           input logic [31:0] d);
    cfg_addr = a;
    cfg_be = b;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    cycle(1);
    cfg_wr = 1'b0;
    cycle(1);
  endtask

  task automatic cfg_read(input logic [7:0] a, input logic [31:0] e);
    cfg_addr = a;
    cfg_rd = 1'b1;
    cycle(1);
    cfg_rd = 1'b0;
    check("cfg_rdata", e, cfg_rdata);
    cycle(1);
  endtask

  task automatic io_pulse(input logic w, input logic r, input logic [15:0] a);
    io_addr = a;
    io_wr = w;
    io_rd = r;
    cycle(1);
    io_wr = 1'b0;
    io_rd = 1'b0;
    cycle(1);
  endtask

  // Latch then release, then bypass, for keyboard (0) or mouse (1).
  task automatic latch_case(input logic m);
    cfg_write(`GENERAL_CONTROL_OFS, 4'hf, m ? 32'h800 : 32'h1000);
    u_legacy_side_model.drive(1'b1, !m, m);
    cycle(1);
    u_legacy_side_model.drive(1'b1, 1'b0, 1'b0);
    cycle(1);
    check("latched", 1, m ? mouse_irq_out : kbd_irq_out);
    io_pulse(1'b0, 1'b1, `PORT_KBD_DATA);
    check("released", 0, m ? mouse_irq_out : kbd_irq_out);
    cfg_write(`GENERAL_CONTROL_OFS, 4'hf, 32'h0);
    u_legacy_side_model.drive(1'b1, !m, m);
    cycle(1);
    check("bypass", 1, m ? mouse_irq_out : kbd_irq_out);
    u_legacy_side_model.drive(1'b1, 1'b0, 1'b0);
    cycle(1);
  endtask

  task automatic end_of_test;
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    {rst, cfg_wr, cfg_rd, io_wr, io_rd, pci_cycle} = 6'h20;
    {cfg_addr, cfg_be, cfg_wdata, io_addr} = '0;
    {pair_b_gpio_sel, cfg_cycle_to_bridge, ad22_request, intc_base_hit,
     intc_ext_hit, msg_irq_write, pci_internal_hit, pci_lpc_known_hit,
     pci_other_claimed} = '0;
    errors = 0;
    total_checks = 0;
    cycle(10);
    rst = 1'b0;
    cfg_read(`GENERAL_CONTROL_OFS, 32'h0);
    cfg_write(`GENERAL_CONTROL_OFS, 4'hf, 32'hffff_ffff);
    cfg_read(`GENERAL_CONTROL_OFS, `GENERAL_CONTROL_MASK);
    cfg_write(8'hd4, 4'hf, 32'h0);
    cfg_read(8'hd4, 32'h0);
    cfg_write(`GENERAL_CONTROL_OFS, 4'h1, 32'h0);
    cfg_read(`GENERAL_CONTROL_OFS, 32'h0300_3900);
    // Register value and side inputs, one steering case per pass.
    pci_cycle = 1'b1;
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: {v, ins} = {32'h0300_0181, 9'b011111000};
        1: {v, ins} = {32'h0000_0146, 9'b111111100};
        2: {v, ins} = {32'h0100_0080, 9'b011111000};
        3: {v, ins} = {32'h0200_0180, 9'b101011010};
        default: {v, ins} = {32'h0, 9'b000000001};
      endcase
      {pair_b_gpio_sel, cfg_cycle_to_bridge, ad22_request, intc_base_hit,
       intc_ext_hit, msg_irq_write, pci_internal_hit, pci_lpc_known_hit,
       pci_other_claimed} = ins;
      cfg_write(`GENERAL_CONTROL_OFS, 4'hf, v);
      check("pcpci", v[25] & !ins[8], pair_b_pcpci_mode);
      check("gpio", ins[8], pair_b_gpio_mode);
      check("ad22", ins[6] & !(ins[7] & v[24]), ad22_drive);
      check("mode", !v[8] ? INTC_OFF : v[7] ? INTC_FULL : INTC_BASE,
            intc_mode);
      check("base", ins[5] & v[8], intc_base_decode);
      check("ext", ins[4] & v[8] & v[7], intc_ext_decode);
      check("msg", ins[3] & v[8] & v[7], msg_irq_accept);
      check("alt", v[6], alternate_access_enable);
      check("dcb", v[2], dma_collect_buffer_enable);
      check("dly", v[1], delayed_transaction_enable);
      check("claim", (ins[2] | ins[1]) ? CLAIM_POSITIVE : (!v[0] && !ins[0])
            ? CLAIM_SUBTRACTIVE : CLAIM_NONE, pci_claim);
      check("fwd", (ins[2] | ins[1]) ? (ins[1] & !ins[2])
            : (!v[0] & !ins[0]), forward_to_lpc);
    end
    cfg_write(`GENERAL_CONTROL_OFS, 4'hf, 32'h2000);
    u_legacy_side_model.drive(1'b0, 1'b0, 1'b0);
    cycle(2);
    check("irq13", 1, irq13);
    check("ignore", 0, ignore_numeric_error_n);
    u_legacy_side_model.drive(1'b1, 1'b0, 1'b0);
    cycle(2);
    check("irq13 held", 1, irq13);
    io_pulse(1'b1, 1'b0, `PORT_FPU_CLEAR);
    check("irq13 clear", 0, irq13);
    cfg_write(`GENERAL_CONTROL_OFS, 4'hf, 32'h0);
    u_legacy_side_model.drive(1'b0, 1'b0, 1'b0);
    cycle(2);
    check("irq13 off", 0, irq13);
    check("ignore off", 1, ignore_numeric_error_n);
    u_legacy_side_model.drive(1'b1, 1'b0, 1'b0);
    latch_case(1'b0);
    latch_case(1'b1);
    end_of_test();
  end
endmodule
